//--- rtl/mmc_conn_decode.sv
// connector or bank enable decode from a two-bit enable field
`timescale 1ns/1ps
module mmc_conn_decode (
	input wire logic [1:0] code,
	input wire logic compat,
	output logic lo_en,
	output logic hi_en,
	output logic bank_en,
	output logic invalid
);
	always_comb begin
		lo_en = 1'b0;
		hi_en = 1'b0;
		bank_en = 1'b0;
		invalid = 1'b0;
		if (compat) begin
			// bit1 is the low-enable, bit0 the high-enable code bit, both active low
			case (code)
				2'b00: begin
					lo_en = 1'b1;
					hi_en = 1'b1;
				end
				2'b01: lo_en = 1'b1;
				2'b10: hi_en = 1'b1;
				default: invalid = 1'b1;
			endcase
			bank_en = lo_en;
		end else begin
			// larger drams: 00 on, 11 off, others reserved
			bank_en = (code == 2'b00);
			invalid = (code == 2'b01) || (code == 2'b10);
		end
	end
endmodule : mmc_conn_decode

//--- rtl/mmc_pkg.sv
// package: register map, field positions and types for memory map config
package mmc_pkg;
	localparam logic [15:0] ENC_TWO_OFS = 16'h00e0;
	localparam logic [15:0] ENC_ONE_OFS = 16'h00e1;
	localparam logic [15:0] CARD_PRES_OFS = 16'h0103;
	localparam logic [15:0] SPLIT_HIGH_OFS = 16'h0183;
	localparam logic [7:0] ENC_TWO_RST = 8'he2;
	localparam logic [7:0] ENC_ONE_RST = 8'heb;
	localparam logic [7:0] CARD_PRES_VAL = 8'hf0;
	localparam logic [7:0] SPLIT_HIGH_RST = 8'h00;
	localparam int PARITY_BIT = 0;
	localparam int ROM_SEL_BIT = 1;
	localparam int BOUNDARY_BIT = 2;
	localparam int SPLIT_DIS_BIT = 3;
	localparam int CONN_LO_BIT = 4;
	localparam int CONN_HI_BIT = 5;
	localparam logic [1:0] SIZE_256K = 2'h0;
	localparam logic [2:0] SPLIT_KB_640 = 3'h5;
	localparam logic [2:0] SPLIT_KB_512 = 3'h4;
	localparam logic [8:0] SPLIT_SIZE_256K = 9'h100;
	localparam logic [8:0] SPLIT_SIZE_384K = 9'h180;
	localparam logic [31:0] SHADOW_BASE = 32'h000e0000;
	localparam logic [31:0] SHADOW_LAST = 32'h000fffff;

	// register bus request
	typedef struct packed {
		logic rd;
		logic wr;
		logic setup;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mmc_req_t;

	// decoded memory configuration seen by the DRAM address path
	typedef struct packed {
		logic parity_en;
		logic rom_select;
		logic split_at_512;
		logic split_en;
		logic [11:0] split_base_mb;
		logic [8:0] split_size_kb;
		logic [3:0] bank_en;
		logic [1:0] bank_mb_a;
		logic [1:0] bank_mb_b;
	} mmc_cfg_t;

	typedef enum logic [1:0] {
		MMC_TGT_RAM,
		MMC_TGT_ROM,
		MMC_TGT_CHANNEL
	} mmc_tgt_t;
endpackage : mmc_pkg

//--- rtl/mmc_regs.sv
// memory map configuration registers and shadow/split decode
`timescale 1ns/1ps
// Functional notes
// - card presence register is read-only and always returns 11110000.
// - connector codes: 00 both halves on, 01 low half only, 10 high half only, 11 invalid.
// - compat mode maps bank0, bank2 to connector one; bank1 to connector two.
// - encoding register one at 00e1, all bits read/write, resets to eb.
// - bit0 of register one: zero enables parity checking.
// - rom select set: shadow reads go to ROM, writes to RAM.
// - rom select clear: shadow reads go to RAM, writes to channel.
// - bit2 selects split boundary: zero 640K, one 512K.
// - bit3 zero maps split memory, one disables it.
// - split size is 256K or 384K by boundary bit, independent of rom select.
// - register one bits 4-5 decode connector one enables.
// - encoding register two at 00e0, resets e2, bits 0-3 split bits 20-23.
// - register two bits 4-5 decode connector two like connector one.
// - connector meaning applies only when all banks hold 256K parts.
// - larger parts: 00 enables bank, 11 disables, 01/10 reserved.
// - setup space 0183 holds split bits 24-31, resets to zero.
module mmc_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire mmc_pkg::mmc_req_t req,
	output logic [7:0] rdata,
	output logic rdata_valid,
	input wire logic [7:0] bank_size_code,
	input wire logic mem_start,
	input wire logic mem_busy,
	input wire logic [31:0] mem_addr,
	input wire logic mem_write,
	output mmc_pkg::mmc_cfg_t cfg,
	output mmc_pkg::mmc_tgt_t mem_target,
	output logic in_split,
	output logic [3:0] conn_enables,
	output logic [1:0] conn_invalid
);
	logic [7:0] enc_one_r;
	logic [7:0] enc_two_r;
	logic [7:0] split_high_r;
	logic [7:0] rdata_nxt;
	logic hit_one;
	logic hit_two;
	logic hit_card;
	logic hit_split;
	logic compat;
	logic [1:0] lo_en;
	logic [1:0] hi_en;
	logic [1:0] bank_en;
	logic [1:0] inval;
	mmc_pkg::mmc_cfg_t cfg_nxt;
	mmc_pkg::mmc_cfg_t cfg_live;
	logic [31:0] split_base;
	logic [31:0] split_end;

	assign hit_one = !req.setup && req.addr == mmc_pkg::ENC_ONE_OFS;
	assign hit_two = !req.setup && req.addr == mmc_pkg::ENC_TWO_OFS;
	assign hit_card = !req.setup && req.addr == mmc_pkg::CARD_PRES_OFS;
	assign hit_split = req.setup && req.addr == mmc_pkg::SPLIT_HIGH_OFS;

	// encoding register one, every bit writable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enc_one_r <= mmc_pkg::ENC_ONE_RST;
		end else if (req.wr && hit_one) begin
			enc_one_r <= req.wdata;
		end
	end

	// encoding register two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enc_two_r <= mmc_pkg::ENC_TWO_RST;
		end else if (req.wr && hit_two) begin
			enc_two_r <= req.wdata;
		end
	end

	// split address extension in setup space
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			split_high_r <= mmc_pkg::SPLIT_HIGH_RST;
		end else if (req.wr && hit_split) begin
			split_high_r <= req.wdata;
		end
	end

	// read mux
	always_comb begin
		rdata_nxt = 8'h00;
		if (hit_one) begin
			rdata_nxt = enc_one_r;
		end else if (hit_two) begin
			rdata_nxt = enc_two_r;
		end else if (hit_card) begin
			rdata_nxt = mmc_pkg::CARD_PRES_VAL;
		end else if (hit_split) begin
			rdata_nxt = split_high_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
			rdata_valid <= 1'b0;
		end else begin
			rdata_valid <= req.rd;
			if (req.rd) begin
				rdata <= rdata_nxt;
			end
		end
	end

	// compat mode only when every bank reports 256K parts
	always_comb begin
		compat = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (bank_size_code[2*i +: 2] != mmc_pkg::SIZE_256K) begin
				compat = 1'b0;
			end
		end
	end

	// one decoder per encoding register
	generate
		for (genvar g = 0; g < 2; g++) begin : g_conn
			mmc_conn_decode u_dec (
				.code(g == 0 ?
					enc_one_r[mmc_pkg::CONN_HI_BIT:mmc_pkg::CONN_LO_BIT] :
					enc_two_r[mmc_pkg::CONN_HI_BIT:mmc_pkg::CONN_LO_BIT]),
				.compat(compat),
				.lo_en(lo_en[g]),
				.hi_en(hi_en[g]),
				.bank_en(bank_en[g]),
				.invalid(inval[g])
			);
		end
	endgenerate

	// live configuration from the registers
	always_comb begin
		cfg_live = '0;
		cfg_live.parity_en = !enc_one_r[mmc_pkg::PARITY_BIT];
		cfg_live.rom_select = enc_one_r[mmc_pkg::ROM_SEL_BIT];
		cfg_live.split_at_512 = enc_one_r[mmc_pkg::BOUNDARY_BIT];
		cfg_live.split_en = !enc_one_r[mmc_pkg::SPLIT_DIS_BIT];
		cfg_live.split_base_mb = {split_high_r, enc_two_r[3:0]};
		cfg_live.split_size_kb = enc_one_r[mmc_pkg::BOUNDARY_BIT] ?
			mmc_pkg::SPLIT_SIZE_384K : mmc_pkg::SPLIT_SIZE_256K;
		if (compat) begin
			// bank0 = conn one low, bank2 = conn one high, bank1 = conn two low
			cfg_live.bank_en = {1'b0, hi_en[0], lo_en[1], lo_en[0]};
		end else begin
			cfg_live.bank_en = {2'b11, bank_en[1], bank_en[0]};
		end
		cfg_live.bank_mb_a = 2'(mmc_pkg::SPLIT_KB_640 - 3'h4);
		cfg_live.bank_mb_b = 2'(mmc_pkg::SPLIT_KB_512 - 3'h4);
		cfg_nxt = cfg;
		if (!mem_busy || mem_start) begin
			cfg_nxt = cfg_live;
		end
	end

	// snapshot held while an access is in flight
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= '0;
		end else begin
			cfg <= cfg_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conn_enables <= 4'h0;
			conn_invalid <= 2'h0;
		end else begin
			conn_enables <= {hi_en[1], lo_en[1], hi_en[0], lo_en[0]};
			conn_invalid <= inval;
		end
	end

	assign split_base = {cfg_live.split_base_mb, 20'h00000};
	assign split_end = split_base + {13'h0000, cfg_live.split_size_kb, 10'h000};

	// target of an access, latched at its start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_target <= mmc_pkg::MMC_TGT_RAM;
			in_split <= 1'b0;
		end else if (mem_start) begin
			in_split <= cfg_live.split_en && mem_addr >= split_base &&
				mem_addr < split_end;
			if (mem_addr >= mmc_pkg::SHADOW_BASE &&
				mem_addr <= mmc_pkg::SHADOW_LAST) begin
				if (cfg_live.rom_select) begin
					mem_target <= mem_write ? mmc_pkg::MMC_TGT_RAM :
						mmc_pkg::MMC_TGT_ROM;
				end else begin
					mem_target <= mem_write ? mmc_pkg::MMC_TGT_CHANNEL :
						mmc_pkg::MMC_TGT_RAM;
				end
			end else begin
				mem_target <= mmc_pkg::MMC_TGT_RAM;
			end
		end
	end

	chk_card_const: assert property (
		@(posedge clk) disable iff (!rst_n)
		req.rd && hit_card |=> rdata == 8'hf0 && rdata_valid)
		else $error("card presence read wrong");
	chk_read_valid: assert property (
		@(posedge clk) disable iff (!rst_n)
		req.rd |=> rdata_valid)
		else $error("read valid missing");
	chk_no_valid: assert property (
		@(posedge clk) disable iff (!rst_n)
		!req.rd |=> !rdata_valid)
		else $error("read valid without read");
	chk_one_read: assert property (
		@(posedge clk) disable iff (!rst_n)
		req.rd && hit_one |=> rdata == $past(enc_one_r))
		else $error("register one read wrong");
	chk_two_read: assert property (
		@(posedge clk) disable iff (!rst_n)
		req.rd && hit_two |=> rdata == $past(enc_two_r))
		else $error("register two read wrong");
	chk_split_read: assert property (
		@(posedge clk) disable iff (!rst_n)
		req.rd && hit_split |=> rdata == $past(split_high_r))
		else $error("split extension read wrong");
	chk_one_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		req.wr && hit_one |=> enc_one_r == $past(req.wdata))
		else $error("register one write lost");
	chk_two_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		req.wr && hit_two |=> enc_two_r == $past(req.wdata))
		else $error("register two write lost");
	chk_split_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		req.wr && hit_split |=> split_high_r == $past(req.wdata))
		else $error("split extension write lost");
	chk_shadow_rom: assert property (
		@(posedge clk) disable iff (!rst_n)
		mem_start && !mem_write && enc_one_r[1] && mem_addr == 32'h000e0000
		|=> mem_target == mmc_pkg::MMC_TGT_ROM)
		else $error("shadow read not sent to rom");
	chk_shadow_chan: assert property (
		@(posedge clk) disable iff (!rst_n)
		mem_start && mem_write && !enc_one_r[1] && mem_addr == 32'h000fffff
		|=> mem_target == mmc_pkg::MMC_TGT_CHANNEL)
		else $error("shadow write not sent to channel");
	chk_below_shadow: assert property (
		@(posedge clk) disable iff (!rst_n)
		mem_start && mem_addr < 32'h000e0000
		|=> mem_target == mmc_pkg::MMC_TGT_RAM)
		else $error("access below shadow not sent to ram");
	chk_cfg_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		mem_busy && !mem_start ##1 mem_busy && !mem_start |-> $stable(cfg))
		else $error("config changed mid access");
	chk_parity_bit: assert property (
		@(posedge clk) disable iff (!rst_n)
		!mem_busy |=> cfg.parity_en == !$past(enc_one_r[0]))
		else $error("parity enable wrong sense");
	chk_rom_cfg: assert property (
		@(posedge clk) disable iff (!rst_n)
		!mem_busy |=> cfg.rom_select == $past(enc_one_r[1]))
		else $error("rom select not applied");
	chk_boundary_bit: assert property (
		@(posedge clk) disable iff (!rst_n)
		!mem_busy |=> cfg.split_at_512 == $past(enc_one_r[2]))
		else $error("split boundary wrong");
	chk_split_en: assert property (
		@(posedge clk) disable iff (!rst_n)
		!mem_busy |=> cfg.split_en == !$past(enc_one_r[3]))
		else $error("split enable wrong sense");
	chk_split_off: assert property (
		@(posedge clk) disable iff (!rst_n)
		mem_start && enc_one_r[3] |=> !in_split)
		else $error("split hit while disabled");
	chk_split_size: assert property (
		@(posedge clk) disable iff (!rst_n)
		!mem_busy && enc_one_r[2] |=> cfg.split_size_kb == 9'h180)
		else $error("split size wrong");
	chk_size_small: assert property (
		@(posedge clk) disable iff (!rst_n)
		!mem_busy && !enc_one_r[2] |=> cfg.split_size_kb == 9'h100)
		else $error("small split size wrong");
	chk_split_low: assert property (
		@(posedge clk) disable iff (!rst_n)
		!mem_busy |=> cfg.split_base_mb[3:0] == $past(enc_two_r[3:0]))
		else $error("split low bits wrong");
	chk_split_ext: assert property (
		@(posedge clk) disable iff (!rst_n)
		!mem_busy |=> cfg.split_base_mb[11:4] == $past(split_high_r))
		else $error("split high bits wrong");
	chk_compat_map: assert property (
		@(posedge clk) disable iff (!rst_n)
		!mem_busy && compat |=> !cfg.bank_en[3])
		else $error("unmapped bank enabled in compat mode");
	chk_conn_one_inv: assert property (
		@(posedge clk) disable iff (!rst_n)
		compat && enc_one_r[5:4] == 2'b11 |=> conn_invalid[0])
		else $error("connector one invalid code missed");
	chk_conn_two_inv: assert property (
		@(posedge clk) disable iff (!rst_n)
		compat && enc_two_r[5:4] == 2'b11 |=> conn_invalid[1])
		else $error("connector two invalid code missed");
	chk_large_bank: assert property (
		@(posedge clk) disable iff (!rst_n)
		!compat && enc_one_r[5:4] == 2'b11 |-> !bank_en[0])
		else $error("disabled bank still enabled");
endmodule : mmc_regs

//--- tb/mmc_host_model.sv
// host processor memory access model for the decode path
`timescale 1ns/1ps
module mmc_host_model (
	input wire logic clk,
	output logic mem_start,
	output logic mem_busy,
	output logic [31:0] mem_addr,
	output logic mem_write
);
	initial begin
		mem_start = 1'b0;
		mem_busy = 1'b0;
		mem_addr = 32'h0;
		mem_write = 1'b0;
	end
	// one access, busy held len extra cycles
	task automatic access(input logic [31:0] a, input logic w, input int len);
		@(posedge clk);
		mem_start <= 1'b1;
		mem_busy <= 1'b1;
		mem_addr <= a;
		mem_write <= w;
		@(posedge clk);
		mem_start <= 1'b0;
		repeat (len) @(posedge clk);
		mem_busy <= 1'b0;
		mem_addr <= ~a;
	endtask : access
endmodule : mmc_host_model

//--- tb/tb_mmc_regs.sv
// bench for the memory map config registers
`timescale 1ns/1ps
module tb_mmc_regs;
	logic clk;
	logic rst_n;
	mmc_pkg::mmc_req_t req;
	logic [7:0] rdata, bank_size_code, e0, e1, sh;
	logic rdata_valid, mem_start, mem_busy, mem_write, in_split, w;
	logic [31:0] mem_addr, a, base, sz;
	mmc_pkg::mmc_cfg_t cfg;
	mmc_pkg::mmc_tgt_t mem_target;
	logic [3:0] conn_enables;
	logic [1:0] conn_invalid;
	int failures = 0;
	int n_checks = 0;
	mmc_regs u_mmc_regs (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
		.rdata_valid(rdata_valid), .bank_size_code(bank_size_code),
		.mem_start(mem_start), .mem_busy(mem_busy), .mem_addr(mem_addr),
		.mem_write(mem_write), .cfg(cfg), .mem_target(mem_target),
		.in_split(in_split), .conn_enables(conn_enables),
		.conn_invalid(conn_invalid));
	mmc_host_model u_mmc_host_model (.clk(clk), .mem_start(mem_start),
		.mem_busy(mem_busy), .mem_addr(mem_addr), .mem_write(mem_write));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %0s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	task automatic bus(input logic r, s, input logic [15:0] ad,
		input logic [7:0] d);
		@(posedge clk);
		req <= '{rd: r, wr: !r, setup: s, addr: ad, wdata: d};
		@(posedge clk);
		req.rd <= 1'b0;
		req.wr <= 1'b0;
		#1;
	endtask : bus
	task automatic rdchk(input logic s, input logic [15:0] ad,
		input logic [7:0] exp);
		bus(1'b1, s, ad, 8'h00);
		chk("rdata_valid", rdata_valid, 1'b1);
		chk("rdata", rdata, exp);
	endtask : rdchk
	function automatic mmc_pkg::mmc_tgt_t exp_tgt(input logic [31:0] ad,
		input logic wr, rom);
		if (ad < 32'h000e0000 || ad > 32'h000fffff)
			return mmc_pkg::MMC_TGT_RAM;
		if (rom)
			return wr ? mmc_pkg::MMC_TGT_RAM : mmc_pkg::MMC_TGT_ROM;
		return wr ? mmc_pkg::MMC_TGT_CHANNEL : mmc_pkg::MMC_TGT_RAM;
	endfunction : exp_tgt
	task automatic acc(input logic [31:0] ad, input logic wr);
		u_mmc_host_model.access(ad, wr, $urandom % 4);
		#1;
	endtask : acc
	initial begin
		repeat (50000) @(posedge clk);
		failures++;
		finish_test;
	end
	initial begin
		rst_n = 1'b0;
		req = '0;
		bank_size_code = 8'h00;
		void'($urandom(42883));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(1'b0, mmc_pkg::ENC_TWO_OFS, 8'he2);
		rdchk(1'b0, mmc_pkg::ENC_ONE_OFS, 8'heb);
		rdchk(1'b0, mmc_pkg::CARD_PRES_OFS, 8'hf0);
		rdchk(1'b1, mmc_pkg::SPLIT_HIGH_OFS, 8'h00);
		bus(1'b0, 1'b0, mmc_pkg::CARD_PRES_OFS, 8'h0f);
		rdchk(1'b0, mmc_pkg::CARD_PRES_OFS, 8'hf0);
		rdchk(1'b0, 16'h0055, 8'h00);
		$display("test reset_map done");
		for (int i = 0; i < 24; i++) begin
			e1 = 8'($urandom) & 8'h3f;
			e0 = 8'($urandom) & 8'h3f;
			e0 = i[0] ? e0 | 8'h01 : (e0 & 8'h38) | 8'h04;
			sh = 8'($urandom);
			@(posedge clk);
			bank_size_code <= i[0] ? 8'h00 : 8'haa;
			bus(1'b0, 1'b0, mmc_pkg::ENC_ONE_OFS, e1);
			bus(1'b0, 1'b0, mmc_pkg::ENC_TWO_OFS, e0);
			bus(1'b0, 1'b1, mmc_pkg::SPLIT_HIGH_OFS, sh);
			rdchk(1'b0, mmc_pkg::ENC_ONE_OFS, e1);
			rdchk(1'b0, mmc_pkg::ENC_TWO_OFS, e0);
			rdchk(1'b1, mmc_pkg::SPLIT_HIGH_OFS, sh);
			chk("parity", cfg.parity_en, !e1[0]);
			chk("boundary", cfg.split_at_512, e1[2]);
			chk("split_en", cfg.split_en, !e1[3]);
			chk("size", cfg.split_size_kb, e1[2] ? 9'h180 : 9'h100);
			chk("base", cfg.split_base_mb, {sh, e0[3:0]});
			if (i[0]) begin
				chk("conn", conn_enables,
					{~e0[4], ~e0[5], ~e1[4], ~e1[5]});
				chk("inval", conn_invalid, {&e0[5:4], &e1[5:4]});
				chk("bank", cfg.bank_en, {1'b0, ~e1[4], ~e0[5], ~e1[5]});
			end else begin
				chk("bank", cfg.bank_en, {2'b11, e0[5:4] == 2'h0,
					e1[5:4] == 2'h0});
				chk("inval", conn_invalid, {^e0[5:4], ^e1[5:4]});
			end
			a = 32'h000e0000 + (32'($urandom) & 32'h1ffff);
			w = 1'($urandom);
			acc(a, w);
			chk("target", mem_target, e1[1] ?
				(w ? mmc_pkg::MMC_TGT_RAM : mmc_pkg::MMC_TGT_ROM) :
				(w ? mmc_pkg::MMC_TGT_CHANNEL : mmc_pkg::MMC_TGT_RAM));
			base = {sh, e0[3:0], 20'h0};
			sz = e1[2] ? 32'h60000 : 32'h40000;
			for (int k = 0; k < 4; k++) begin
				a = base - 32'h1 + (k == 3 ? 32'($urandom) % 32'h68000 :
					(k == 2 ? sz + 32'h1 : k * sz));
				w = 1'($urandom);
				acc(a, w);
				chk("in_split", in_split, !e1[3] && a >= base &&
					a - base < sz);
				chk("target", mem_target, exp_tgt(a, w, e1[1]));
			end
		end
		$display("test config_decode done");
		e1 = e1 ^ 8'h02;
		fork
			u_mmc_host_model.access(32'h000e0000, 1'b0, 8);
			begin
				bus(1'b0, 1'b0, mmc_pkg::ENC_ONE_OFS, e1);
				repeat (3) @(posedge clk);
				#1;
				chk("hold", cfg.rom_select, !e1[1]);
			end
		join
		repeat (2) @(posedge clk);
		#1;
		chk("apply", cfg.rom_select, e1[1]);
		$display("test busy_hold done");
		bus(1'b0, 1'b0, mmc_pkg::ENC_ONE_OFS, 8'h02);
		acc(32'h000e0000, 1'b0);
		chk("copy_rd", mem_target, mmc_pkg::MMC_TGT_ROM);
		acc(32'h000e0000, 1'b1);
		chk("copy_wr", mem_target, mmc_pkg::MMC_TGT_RAM);
		bus(1'b0, 1'b0, mmc_pkg::ENC_ONE_OFS, 8'h00);
		acc(32'h000fffff, 1'b0);
		chk("run_rd", mem_target, mmc_pkg::MMC_TGT_RAM);
		acc(32'h000fffff, 1'b1);
		chk("run_wr", mem_target, mmc_pkg::MMC_TGT_CHANNEL);
		$display("test shadow_copy done");
		finish_test;
	end
endmodule : tb_mmc_regs
